// ===== hw/aprr_pkg.sv
// package: register map, field layout, reset values and timing for the ambient/proximity block
package aprr_pkg;
  // ---------------------------------------------------------------
  // register offsets (printed offsets are not all multiples of four: index, byte addr = 4*index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_AMB_PARAMS = 8'h84;
  localparam logic [7:0] IDX_AMB_HI = 8'h85;
  localparam logic [7:0] IDX_AMB_LO = 8'h86;
  localparam logic [7:0] IDX_PROX_HI = 8'h87;
  localparam logic [7:0] IDX_PROX_LO = 8'h88;
  localparam logic [7:0] IDX_MEAS_CTRL = 8'h90;
  localparam logic [7:0] IDX_MEAS_STAT = 8'h91;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_CONT_CONV = 7;
  localparam int POS_RATE = 4;
  localparam int BIT_OFFS_COMP = 3;
  localparam int POS_AVG = 0;
  localparam int BIT_SELF_TIMED = 0;
  localparam int BIT_AMB_DEMAND = 1;
  localparam int BIT_PROX_DEMAND = 2;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_AMB_PARAMS = 8'h08;
  localparam logic [15:0] RST_RESULT = 16'h0000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 100;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int CONV_NS = 200;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {APRR_IDLE, APRR_OFFS, APRR_CONV, APRR_STORE} aprr_state_e;
endpackage : aprr_pkg

// ===== hw/aprr_conv_if.sv
// interface: request and result between measurement sequencer and converter
interface aprr_conv_if;
  logic start;
  logic done;
  logic [15:0] data;
  modport seq (output start, input done, input data);
  modport conv (input start, output done, output data);
endinterface : aprr_conv_if

// ===== hw/aprr_conv.sv
// converter front end: latches a sample after a fixed conversion time
module aprr_conv #(
  parameter int CONV_CYCLES = aprr_pkg::CONV_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] sample,
  aprr_conv_if.conv cif
);
  logic [7:0] cnt_r;
  logic busy_r;
  logic [15:0] data_r;
  logic done_r;
  // ---------------------------------------------------------------
  // conversion timer
  // ---------------------------------------------------------------
  wire fin = busy_r && (cnt_r == 8'(CONV_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      data_r <= 16'h0000;
    end else begin
      done_r <= fin;
      if (fin) data_r <= sample;
      busy_r <= (busy_r && !fin) || (cif.start && !busy_r);
      cnt_r <= busy_r && !fin ? cnt_r + 8'h01 : 8'h00;
    end
  end
  assign cif.done = done_r;
  assign cif.data = data_r;
  a_conv_len: assert property (@(posedge clk) disable iff (!rst_b)
    (cif.start && !busy_r) |-> ##(CONV_CYCLES + 1) cif.done)
    else $error("conversion done not on time");
endmodule : aprr_conv

// ===== hw/aprr_top.sv
// ambient light parameter and result registers with measurement sequencer, apb slave
module aprr_top #(
  parameter int TICK_CYCLES = aprr_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] amb_sample,
  input wire logic [15:0] prox_sample,
  output logic [2:0] run_rate,
  output logic [2:0] run_avg,
  output logic run_cont_conv
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] params_r;
  logic [7:0] active_r;
  logic [7:0] ctrl_r;
  logic [15:0] amb_r;
  logic [15:0] prox_r;
  logic self_timed_q_r;
  logic [31:0] prdata_r;
  logic pending_r;
  aprr_pkg::aprr_state_e state_r;
  aprr_pkg::aprr_state_e state_nxt;
  logic is_prox_r;
  logic [15:0] offs_r;
  logic [7:0] avg_cnt_r;
  logic [23:0] acc_r;
  logic [31:0] tick_cnt_r;
  logic [31:0] period_r;
  aprr_conv_if cif ();

  // rate code to samples per second
  function automatic logic [3:0] rate_sps(input logic [2:0] code);
    case (code)
      3'h6: rate_sps = 4'h8;
      3'h7: rate_sps = 4'ha;
      default: rate_sps = 4'(code) + 4'h1;
    endcase
  endfunction : rate_sps

  // averaging count: 2^value conversions, e.g. 0 means one
  function automatic logic [7:0] avg_runs(input logic [2:0] code);
    avg_runs = 8'h01 << code;
  endfunction : avg_runs

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire [9:0] word_idx = paddr[11:2];
  wire acc_ok = paddr[1:0] == 2'b00;
  wire hit_params = acc_ok && word_idx == {2'b00, aprr_pkg::IDX_AMB_PARAMS};
  wire hit_amb_hi = acc_ok && word_idx == {2'b00, aprr_pkg::IDX_AMB_HI};
  wire hit_amb_lo = acc_ok && word_idx == {2'b00, aprr_pkg::IDX_AMB_LO};
  wire hit_prox_hi = acc_ok && word_idx == {2'b00, aprr_pkg::IDX_PROX_HI};
  wire hit_prox_lo = acc_ok && word_idx == {2'b00, aprr_pkg::IDX_PROX_LO};
  wire hit_ctrl = acc_ok && word_idx == {2'b00, aprr_pkg::IDX_MEAS_CTRL};
  wire hit_stat = acc_ok && word_idx == {2'b00, aprr_pkg::IDX_MEAS_STAT};
  wire hit_any = hit_params || hit_amb_hi || hit_amb_lo || hit_prox_hi || hit_prox_lo
    || hit_ctrl || hit_stat;
  wire apb_acc = psel && penable;
  wire wr_params = apb_acc && pwrite && hit_params;
  wire wr_ctrl = apb_acc && pwrite && hit_ctrl;
  wire self_timed = ctrl_r[aprr_pkg::BIT_SELF_TIMED];
  wire busy = state_r != aprr_pkg::APRR_IDLE;
  wire [7:0] stat_val = {5'h00, pending_r, self_timed, busy};
  // result bytes only ever come from the sequencer; no write path exists
  wire [7:0] rd_byte = hit_params ? params_r :
    hit_amb_hi ? amb_r[15:8] :
    hit_amb_lo ? amb_r[7:0] :
    hit_prox_hi ? prox_r[15:8] :
    hit_prox_lo ? prox_r[7:0] :
    hit_ctrl ? ctrl_r :
    hit_stat ? stat_val : 8'h00;
  assign pready = 1'b1;
  assign pslverr = apb_acc && !hit_any;
  assign prdata = prdata_r;

  // read data held in a flop, loaded in the setup cycle
  always_ff @(posedge clk) begin
    if (!rst_b) prdata_r <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata_r <= {24'h000000, rd_byte};
  end

  // ---------------------------------------------------------------
  // parameter register and the copy that the sequencer uses
  // ---------------------------------------------------------------
  // a held write is applied as soon as self-timed mode stops (falls); the copy also loads on a rise
  wire st_start = self_timed && !self_timed_q_r;
  wire take_now = !self_timed || st_start;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      params_r <= aprr_pkg::RST_AMB_PARAMS;
      active_r <= aprr_pkg::RST_AMB_PARAMS;
      pending_r <= 1'b0;
      ctrl_r <= aprr_pkg::RST_CTRL;
      self_timed_q_r <= 1'b0;
    end else begin
      if (wr_params) params_r <= pwdata[7:0];
      if (take_now) active_r <= params_r;
      pending_r <= wr_params ? self_timed : (pending_r && !take_now);
      self_timed_q_r <= self_timed;
      if (wr_ctrl) ctrl_r <= pwdata[7:0];
      else ctrl_r <= {ctrl_r[7:3], 2'b00, ctrl_r[0]}; // demand bits self clear
    end
  end
  wire comp_on = active_r[aprr_pkg::BIT_OFFS_COMP];
  wire [2:0] rate = active_r[aprr_pkg::POS_RATE +: 3];
  wire [2:0] avg = active_r[aprr_pkg::POS_AVG +: 3];
  assign run_rate = active_r[aprr_pkg::POS_RATE +: 3];
  assign run_avg = active_r[aprr_pkg::POS_AVG +: 3];
  assign run_cont_conv = active_r[aprr_pkg::BIT_CONT_CONV];

  // ---------------------------------------------------------------
  // self-timed rate tick
  // ---------------------------------------------------------------
  // period per sample = tick base * 10 / sps; divide recomputed and registered every cycle
  wire tick = self_timed && tick_cnt_r >= period_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt_r <= 32'h0000_0000;
      period_r <= 32'h0000_0001;
    end else begin
      period_r <= 32'((TICK_CYCLES * 10) / int'(rate_sps(rate)));
      tick_cnt_r <= (!self_timed || tick) ? 32'h0000_0000 : tick_cnt_r + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // measurement sequencer
  // ---------------------------------------------------------------
  wire amb_req = ctrl_r[aprr_pkg::BIT_AMB_DEMAND] || tick;
  wire prox_req = ctrl_r[aprr_pkg::BIT_PROX_DEMAND];
  wire last_run = avg_cnt_r == 8'h01;
  wire [15:0] comp_val = cif.data > offs_r ? cif.data - offs_r : 16'h0000;
  wire [23:0] acc_sum = acc_r + {8'h00, (is_prox_r || !comp_on) ? cif.data : comp_val};
  wire [23:0] acc_avg = acc_sum >> avg;
  assign cif.start = (state_r == aprr_pkg::APRR_IDLE && (amb_req || prox_req))
    || (state_r == aprr_pkg::APRR_OFFS && cif.done)
    || (state_r == aprr_pkg::APRR_CONV && cif.done && !last_run);
  wire [15:0] conv_in = (state_r == aprr_pkg::APRR_OFFS || (cif.start
    && state_r == aprr_pkg::APRR_IDLE && comp_on && !prox_req)) ? 16'h0000 :
    (is_prox_r ? prox_sample : amb_sample);

  // next state; an offset run precedes every ambient conversion when compensation is on
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      aprr_pkg::APRR_IDLE:
        if (prox_req) state_nxt = aprr_pkg::APRR_CONV;
        else if (amb_req) state_nxt = comp_on ? aprr_pkg::APRR_OFFS : aprr_pkg::APRR_CONV;
      aprr_pkg::APRR_OFFS:
        if (cif.done) state_nxt = aprr_pkg::APRR_CONV;
      aprr_pkg::APRR_CONV:
        if (cif.done && last_run) state_nxt = aprr_pkg::APRR_STORE;
        else if (cif.done && !is_prox_r && comp_on) state_nxt = aprr_pkg::APRR_OFFS;
      aprr_pkg::APRR_STORE:
        state_nxt = aprr_pkg::APRR_IDLE;
      default:
        state_nxt = aprr_pkg::APRR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= aprr_pkg::APRR_IDLE;
      is_prox_r <= 1'b0;
      offs_r <= 16'h0000;
      avg_cnt_r <= 8'h00;
      acc_r <= 24'h000000;
      amb_r <= aprr_pkg::RST_RESULT;
      prox_r <= aprr_pkg::RST_RESULT;
    end else begin
      state_r <= state_nxt;
      if (state_r == aprr_pkg::APRR_IDLE) begin
        is_prox_r <= prox_req;
        avg_cnt_r <= avg_runs(avg);
        acc_r <= 24'h000000;
      end
      if (state_r == aprr_pkg::APRR_OFFS && cif.done) offs_r <= cif.data;
      if (state_r == aprr_pkg::APRR_CONV && cif.done) begin
        acc_r <= acc_sum;
        avg_cnt_r <= avg_cnt_r - 8'h01;
        if (last_run && is_prox_r) prox_r <= acc_avg[15:0];
        if (last_run && !is_prox_r) amb_r <= acc_avg[15:0];
      end
    end
  end

  aprr_conv u_conv (
    .clk(clk),
    .rst_b(rst_b),
    .sample(conv_in),
    .cif(cif)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_result_ro: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r != aprr_pkg::APRR_CONV) |=> $stable(amb_r) && $stable(prox_r))
    else $error("result changed outside a conversion");
  a_hold_write: assert property (@(posedge clk) disable iff (!rst_b)
    (self_timed && $past(self_timed)) |-> $stable(active_r))
    else $error("parameters changed while self-timed runs");
  a_comp_first: assert property (@(posedge clk) disable iff (!rst_b)
    (state_r == aprr_pkg::APRR_IDLE && amb_req && !prox_req && comp_on)
    |=> state_r == aprr_pkg::APRR_OFFS)
    else $error("no offset run before ambient conversion");
  a_rd_amb_hi: assert property (@(posedge clk) disable iff (!rst_b)
    (psel && !penable && !pwrite && hit_amb_hi) |=> prdata == {24'h0, $past(amb_r[15:8])})
    else $error("ambient high byte misread");
  a_rd_prox_lo: assert property (@(posedge clk) disable iff (!rst_b)
    (psel && !penable && !pwrite && hit_prox_lo) |=> prdata == {24'h0, $past(prox_r[7:0])})
    else $error("proximity low byte misread");
  a_param_take: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_params && !self_timed) ##1 !self_timed |=> active_r == $past(params_r))
    else $error("parameter write not applied");
  a_reset_vals: assert property (@(posedge clk)
    !rst_b |=> params_r == 8'h08 && run_cont_conv == 1'b0)
    else $error("bad parameter reset value");
  a_cont_bit: assert property (@(posedge clk) disable iff (!rst_b)
    take_now |=> run_cont_conv == $past(params_r[aprr_pkg::BIT_CONT_CONV]))
    else $error("continuous bit not taken over");
  a_rate_period: assert property (@(posedge clk) disable iff (!rst_b)
    $stable(rate) |=> period_r == 32'((TICK_CYCLES * 10) / int'(rate_sps($past(rate)))))
    else $error("wrong sample period");
  c_amb_store: cover property (@(posedge clk) disable iff (!rst_b)
    state_r == aprr_pkg::APRR_STORE && !is_prox_r);
  c_prox_store: cover property (@(posedge clk) disable iff (!rst_b)
    state_r == aprr_pkg::APRR_STORE && is_prox_r);
  c_held_write: cover property (@(posedge clk) disable iff (!rst_b) wr_params && self_timed);
  c_bad_addr: cover property (@(posedge clk) disable iff (!rst_b) pslverr);
endmodule : aprr_top

// ===== tb/aprr_front_model.sv
// front-end model: photodiode channels feeding the converter inputs
module aprr_front_model (
  input wire logic [15:0] amb_level,
  input wire logic [15:0] prox_level,
  output logic [15:0] amb_sample,
  output logic [15:0] prox_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  // settled light levels; the dark offset of this model is zero, so results equal the level
  always_comb amb_sample = amb_level;
  always_comb prox_sample = prox_level;
endmodule : aprr_front_model

// ===== tb/aprr_bench.sv
// testbench: apb register traffic and measurement runs against the result registers
module aprr_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] amb_level = 16'h0000;
  logic [15:0] prox_level = 16'h0000;
  logic [15:0] amb_sample;
  logic [15:0] prox_sample;
  logic [2:0] run_rate;
  logic [2:0] run_avg;
  logic run_cont_conv;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [32:0] exp_q[$];
  bit quiet = 1'b0;

  always #5 clk = ~clk;

  aprr_top #(.TICK_CYCLES(TICK)) i_aprr_top (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .amb_sample(amb_sample), .prox_sample(prox_sample),
    .run_rate(run_rate), .run_avg(run_avg), .run_cont_conv(run_cont_conv));
  aprr_front_model i_aprr_front_model (.amb_level(amb_level), .prox_level(prox_level),
    .amb_sample(amb_sample), .prox_sample(prox_sample));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task finish_test;
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // monitor: each completed access except the quiet status polls is compared with the oldest note; write data is masked
  always @(posedge clk) begin
    if (rst_b && psel && penable && pready === 1'b1 && !quiet) begin
      check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // apb master
  // ---------------------------------------------------------------
  // entered just after an edge; an idle edge at the end keeps strobes from double assignment
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [32:0] expv, output logic [31:0] rd);
    int n;
    n = 0;
    if (!quiet) exp_q.push_back(expv);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic w(input logic [7:0] idx, input logic [7:0] d, input logic e);
    logic [31:0] x;
    apb(1'b1, idx, d, {e, 32'h0}, x);
  endtask : w

  task automatic r(input logic [7:0] idx, input logic [7:0] d, input logic e);
    logic [31:0] x;
    apb(1'b0, idx, 8'h00, {e, 24'h00_0000, d}, x);
  endtask : r

  // polls the busy flag; a run that never ends counts as a mismatch
  task automatic wait_idle;
    logic [31:0] s;
    int k;
    quiet = 1'b1;
    s = 32'h1;
    k = 0;
    while (s[0] !== 1'b0 && k < 80) begin
      apb(1'b0, aprr_pkg::IDX_MEAS_STAT, 8'h00, 33'h0, s);
      k++;
    end
    quiet = 1'b0;
    if (k >= 80) n_mismatch++;
  endtask : wait_idle

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] p;
    logic [15:0] a;
    int i;
    void'($urandom(15));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check({26'h0, run_cont_conv, run_rate, run_avg}, 33'h0);
    r(aprr_pkg::IDX_AMB_PARAMS, 8'h08, 1'b0);
    // every rate code, with the other fields varied alongside
    for (i = 0; i < 8; i++) begin
      p = {i[0], i[2:0], ~i[1], 3'($urandom_range(7))};
      w(aprr_pkg::IDX_AMB_PARAMS, p, 1'b0);
      r(aprr_pkg::IDX_AMB_PARAMS, p, 1'b0);
      check({26'h0, run_cont_conv, run_rate, run_avg}, {26'h0, p[7], p[6:4], p[2:0]});
    end
    // result bytes refuse writes before any conversion has run
    for (i = 0; i < 4; i++) begin
      w(aprr_pkg::IDX_AMB_HI + 8'(i), 8'($urandom), 1'b0);
      r(aprr_pkg::IDX_AMB_HI + 8'(i), 8'h00, 1'b0);
    end
    // ambient on demand with compensation on and a small averaging count
    w(aprr_pkg::IDX_AMB_PARAMS, {5'b00001, 3'($urandom_range(2))}, 1'b0);
    a = 16'($urandom);
    amb_level <= a;
    prox_level <= 16'($urandom);
    w(aprr_pkg::IDX_MEAS_CTRL, 8'h02, 1'b0);
    wait_idle();
    r(aprr_pkg::IDX_AMB_HI, a[15:8], 1'b0);
    w(aprr_pkg::IDX_AMB_LO, ~a[7:0], 1'b0);
    r(aprr_pkg::IDX_AMB_LO, a[7:0], 1'b0);
    w(aprr_pkg::IDX_MEAS_CTRL, 8'h04, 1'b0);
    wait_idle();
    r(aprr_pkg::IDX_PROX_HI, prox_level[15:8], 1'b0);
    w(aprr_pkg::IDX_PROX_HI, ~prox_level[15:8], 1'b0);
    r(aprr_pkg::IDX_PROX_HI, prox_level[15:8], 1'b0);
    r(aprr_pkg::IDX_PROX_LO, prox_level[7:0], 1'b0);
    // parameter change held back while self-timed runs, applied after a stop and restart
    w(aprr_pkg::IDX_MEAS_CTRL, 8'h01, 1'b0);
    w(aprr_pkg::IDX_AMB_PARAMS, 8'h3a, 1'b0);
    check({30'h0, run_rate}, {30'h0, 3'h0});
    w(aprr_pkg::IDX_MEAS_CTRL, 8'h00, 1'b0);
    w(aprr_pkg::IDX_MEAS_CTRL, 8'h01, 1'b0);
    check({27'h0, run_rate, run_avg}, 33'h1a);
    w(aprr_pkg::IDX_MEAS_CTRL, 8'h00, 1'b0);
    // unmapped place: error flagged, read data zero
    r(8'h89, 8'h00, 1'b1);
    w(8'h89, 8'hff, 1'b1);
    // second reset in mid-run restores the defaults
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    r(aprr_pkg::IDX_AMB_PARAMS, 8'h08, 1'b0);
    finish_test();
  end

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end
endmodule : aprr_bench
